// File: logic/alu_pkg.sv
/*
  Constants and types shared by the integer arithmetic unit and its divider.
  Assumes a single 20 MHz clock and an active-low asynchronous reset.
*/
// Summary of operation
// - add and subtract with carry fold the carry flag into the result
// - decimal add and subtract are byte only, packed BCD, with carry
// - unsigned multiply of 8x8 or 16x16 operands into the destination
// - unsigned divide 16/8 or 32/16, quotient and remainder to destination
// - compare subtracts operands, updates flags only, writes nothing
// - zero extend clears bits 15 to 8
// - zero compare tests operand against zero, flags only
// - negate replaces operand by zero minus operand
// - zero store writes an all-zero byte or word
// - test then set: flags from operand, write back with bit 7 set
package alu_pkg;
  localparam int unsigned ref_clk_hz = 20_000_000;
  localparam int unsigned word_w = 16;
  localparam int unsigned div_steps_byte = 8;
  localparam int unsigned div_steps_word = 16;
  localparam logic [3:0] flags_reset = 4'h0;
  localparam logic [31:0] result_reset = 32'h0000_0000;
  localparam int unsigned flag_c = 0;
  localparam int unsigned flag_v = 1;
  localparam int unsigned flag_z = 2;
  localparam int unsigned flag_n = 3;
  typedef enum logic [3:0] {
    add_with_carry,
    subtract_with_borrow,
    decimal_add,
    decimal_subtract,
    unsigned_multiply,
    unsigned_divide,
    compare_op,
    sign_extend_byte,
    zero_extend_byte,
    zero_compare,
    negate_op,
    zero_store,
    test_then_set_msb
  } alu_op_t;
endpackage : alu_pkg

// File: logic/serial_divider.sv
/*
  Restoring unsigned divider, one quotient bit per clock.
  Assumes start is only pulsed while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_divider (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic word_in,
  input wire logic [31:0] dividend_in,
  input wire logic [15:0] divisor_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] quotient_out,
  output logic [15:0] remainder_out
);
  import alu_pkg::*;
  logic [16:0] rem;
  logic [31:0] shreg;
  logic [15:0] dsr;
  logic [4:0] count;
  logic wide;
  logic [16:0] trial;
  logic [16:0] shifted;

  always_comb begin
    // byte mode keeps the running remainder in the low 9 bits
    shifted = wide ? {rem[15:0], shreg[31]} : {8'h00, rem[7:0], shreg[15]};
    trial = shifted - {1'b0, dsr};
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rem <= 17'h00000;
      shreg <= 32'h0000_0000;
      dsr <= 16'h0000;
      count <= 5'h00;
      wide <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      quotient_out <= 16'h0000;
      remainder_out <= 16'h0000;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        wide <= word_in;
        dsr <= divisor_in;
        // high half seeds the remainder so every low dividend bit is shifted through;
        // a high half not below the divisor overflows the quotient and is not flagged
        shreg <= word_in ? {dividend_in[15:0], 16'h0000} : {16'h0000, dividend_in[7:0], 8'h00};
        rem <= word_in ? {1'b0, dividend_in[31:16]} : {9'h000, dividend_in[15:8]};
        count <= word_in ? 5'(div_steps_word) : 5'(div_steps_byte);
      end else if (busy_out) begin
        if (!trial[16]) begin
          rem <= trial;
        end else begin
          rem <= shifted;
        end
        shreg <= {shreg[30:0], ~trial[16]};
        count <= count - 5'h01;
        if (count == 5'h01) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          quotient_out <= wide ? {shreg[14:0], ~trial[16]} : {8'h00, shreg[6:0], ~trial[16]};
          remainder_out <= !trial[16] ? trial[15:0] : shifted[15:0];
        end
      end
    end
  end
endmodule : serial_divider
`default_nettype wire

// File: logic/integer_arithmetic_unit.sv
/*
  Arithmetic execution datapath: carry arithmetic, BCD, multiply, divide,
  compare, extensions, test, negate, clear and test-and-set.
  Assumes the sequencer presents operands with a one-cycle start pulse and
  waits for done before the next start.
*/
`timescale 1ns/1ps
`default_nettype none
module integer_arithmetic_unit (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire alu_pkg::alu_op_t op_in,
  input wire logic word_in,
  input wire logic [31:0] dest_in,
  input wire logic [15:0] source_operand_in,
  input wire logic carry_in,
  output logic done_out,
  output logic write_out,
  output logic [31:0] result_out,
  output logic [3:0] flags_out
);
  import alu_pkg::*;

  logic div_start;
  logic div_busy;
  logic div_done;
  logic [15:0] div_quot;
  logic [15:0] div_rem;
  logic div_word;
  logic div_zero;
  logic [31:0] next_result;
  logic [3:0] next_flags;
  logic next_write;

  // flags at the selected size; v and c supplied by caller
  function automatic logic [3:0] size_flags(input logic [15:0] r, input logic wd, input logic v, input logic c);
    logic [3:0] f;
    f = 4'h0;
    f[flag_n] = wd ? r[15] : r[7];
    f[flag_z] = wd ? (r == 16'h0000) : (r[7:0] == 8'h00);
    f[flag_v] = v;
    f[flag_c] = c;
    return f;
  endfunction : size_flags

  // one BCD digit step, returns {carry, digit}
  function automatic logic [4:0] bcd_digit(input logic [3:0] a, input logic [3:0] b, input logic ci,
                                           input logic sub);
    logic [4:0] s;
    s = 5'h00;
    if (!sub) begin
      s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
      if (s > 5'h09) begin
        s = (s + 5'h06) | 5'h10;
      end
    end else begin
      s = {1'b0, a} - {1'b0, b} - {4'h0, ci};
      if (s[4]) begin
        s = (s - 5'h06) | 5'h10;
      end
    end
    return {s[4], s[3:0]};
  endfunction : bcd_digit

  serial_divider u_div (
    .clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .start_in(div_start),
    .word_in(word_in),
    .dividend_in(word_in ? dest_in : {16'h0000, dest_in[15:0]}),
    .divisor_in(word_in ? source_operand_in : {8'h00, source_operand_in[7:0]}),
    .busy_out(div_busy),
    .done_out(div_done),
    .quotient_out(div_quot),
    .remainder_out(div_rem)
  );

  // zero divisor bypasses the divider and completes at once
  assign div_zero = word_in ? (source_operand_in == 16'h0000) : (source_operand_in[7:0] == 8'h00);
  assign div_start = start_in && (op_in == unsigned_divide) && !div_zero && !div_busy;

  always_comb begin
    logic [16:0] sum;
    logic [8:0] sum_b;
    logic [4:0] lo;
    logic [4:0] hi;
    logic [15:0] a;
    logic [15:0] b;
    logic v;
    logic c;
    sum = 17'h00000;
    sum_b = 9'h000;
    lo = 5'h00;
    hi = 5'h00;
    a = dest_in[15:0];
    b = source_operand_in;
    v = 1'b0;
    c = 1'b0;
    next_result = dest_in;
    next_write = 1'b0;
    next_flags = flags_out;
    case (op_in)
      add_with_carry, subtract_with_borrow, compare_op, negate_op: begin
        if (op_in == negate_op) begin
          b = dest_in[15:0];
          a = 16'h0000;
        end
        if (op_in == add_with_carry) begin
          sum = {1'b0, a} + {1'b0, b} + {16'h0000, carry_in};
          sum_b = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, carry_in};
        end else begin
          sum = {1'b0, a} - {1'b0, b} - {16'h0000, (op_in == subtract_with_borrow) & carry_in};
          sum_b = {1'b0, a[7:0]} - {1'b0, b[7:0]} - {8'h00, (op_in == subtract_with_borrow) & carry_in};
        end
        c = word_in ? sum[16] : sum_b[8];
        if (op_in == add_with_carry) begin
          v = word_in ? (a[15] == b[15]) && (sum[15] != a[15]) : (a[7] == b[7]) && (sum[7] != a[7]);
        end else begin
          v = word_in ? (a[15] != b[15]) && (sum[15] != a[15]) : (a[7] != b[7]) && (sum[7] != a[7]);
        end
        next_flags = size_flags(sum[15:0], word_in, v, c);
        if (op_in == compare_op) begin
          next_write = 1'b0;
        end else begin
          next_write = 1'b1;
          next_result[15:0] = word_in ? sum[15:0] : {dest_in[15:8], sum[7:0]};
        end
      end
      decimal_add, decimal_subtract: begin
        lo = bcd_digit(dest_in[3:0], source_operand_in[3:0], carry_in, op_in == decimal_subtract);
        hi = bcd_digit(dest_in[7:4], source_operand_in[7:4], lo[4], op_in == decimal_subtract);
        next_result[7:0] = {hi[3:0], lo[3:0]};
        next_write = 1'b1;
        next_flags = size_flags({8'h00, hi[3:0], lo[3:0]}, 1'b0, 1'b0, hi[4]);
      end
      unsigned_multiply: begin
        if (word_in) begin
          // operands widened first: a self-sized product would lose its upper half
          next_result = 32'(dest_in[15:0]) * 32'(source_operand_in);
          next_flags = size_flags(16'h0000, 1'b1, 1'b0, 1'b0);
          next_flags[flag_n] = next_result[31];
          next_flags[flag_z] = (next_result == 32'h0000_0000);
        end else begin
          next_result = {16'h0000, 16'(dest_in[7:0]) * 16'(source_operand_in[7:0])};
          next_flags = size_flags(next_result[15:0], 1'b1, 1'b0, 1'b0);
        end
        next_write = 1'b1;
      end
      unsigned_divide: begin
        // divide by zero: destination kept, V and Z raised
        next_flags = size_flags(16'h0000, word_in, 1'b1, 1'b0);
        next_write = 1'b0;
      end
      sign_extend_byte: begin
        next_result[15:0] = {{8{dest_in[7]}}, dest_in[7:0]};
        next_write = 1'b1;
        next_flags = size_flags(next_result[15:0], 1'b1, 1'b0, 1'b0);
      end
      zero_extend_byte: begin
        next_result[15:0] = {8'h00, dest_in[7:0]};
        next_write = 1'b1;
        next_flags = size_flags(next_result[15:0], 1'b1, 1'b0, 1'b0);
      end
      zero_compare: begin
        next_flags = size_flags(dest_in[15:0], word_in, 1'b0, 1'b0);
      end
      zero_store: begin
        next_result[15:0] = word_in ? 16'h0000 : {dest_in[15:8], 8'h00};
        next_write = 1'b1;
        next_flags = size_flags(16'h0000, word_in, 1'b0, 1'b0);
      end
      test_then_set_msb: begin
        next_flags = size_flags(dest_in[15:0], 1'b0, 1'b0, 1'b0);
        next_result[7] = 1'b1;
        next_write = 1'b1;
      end
      default: begin
        next_write = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_out <= 1'b0;
      write_out <= 1'b0;
      result_out <= result_reset;
      flags_out <= flags_reset;
      div_word <= 1'b0;
    end else begin
      done_out <= 1'b0;
      write_out <= 1'b0;
      if (div_start) begin
        div_word <= word_in;
      end
      if (div_done) begin
        // remainder in upper half, quotient in lower half
        result_out <= div_word ? {div_rem, div_quot} : {16'h0000, div_rem[7:0], div_quot[7:0]};
        flags_out <= size_flags(div_quot, div_word, 1'b0, 1'b0);
        done_out <= 1'b1;
        write_out <= 1'b1;
      end else if (start_in && !div_start && !div_busy) begin
        result_out <= next_result;
        flags_out <= next_flags;
        write_out <= next_write;
        done_out <= 1'b1;
      end
    end
  end

  property cmp_nowrite_p;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (start_in && !div_busy && op_in == compare_op) |=> done_out && !write_out;
  endproperty
  compare_no_write_a: assert property (cmp_nowrite_p) else $error("compare wrote result");

  clear_zero_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == zero_store && word_in) |=> result_out[15:0] == 16'h0000 && flags_out[flag_z])
    else $error("clear not zero");

  clear_byte_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == zero_store && !word_in) |=>
      result_out[15:0] == {$past(dest_in[15:8]), 8'h00} && write_out)
    else $error("byte clear wrong");

  negate_value_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == negate_op && word_in) |=>
      result_out[15:0] == 16'(16'h0000 - $past(dest_in[15:0])))
    else $error("negate wrong");

  sign_ext_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == sign_extend_byte) |=> result_out[15:8] == {8{$past(dest_in[7])}})
    else $error("sign extend wrong");

  zero_ext_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == zero_extend_byte) |=> result_out[15:8] == 8'h00 && write_out)
    else $error("zero extend wrong");

  tas_msb_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == test_then_set_msb) |=>
      result_out[7] && flags_out[flag_n] == $past(dest_in[7]))
    else $error("test-and-set wrong");

  test_flags_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == zero_compare && word_in) |=>
      !write_out && flags_out[flag_z] == ($past(dest_in[15:0]) == 16'h0000))
    else $error("test flags wrong");

  mul_word_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == unsigned_multiply && word_in) |=>
      result_out == $past(dest_in[15:0]) * $past(source_operand_in))
    else $error("multiply wrong");

  mul_byte_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == unsigned_multiply && !word_in) |=>
      result_out[15:0] == 16'($past(dest_in[7:0])) * 16'($past(source_operand_in[7:0])))
    else $error("byte multiply wrong");

  sequence div_run_s;
    div_busy [*8];
  endsequence
  // the divider drops busy one edge before the unit registers its answer
  sequence div_finish_s;
    !div_busy ##1 done_out && write_out;
  endsequence
  div_time_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (div_start && !word_in) |=> div_run_s ##1 div_finish_s)
    else $error("byte divide timing wrong");

  div_word_time_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (div_start && word_in) |=> div_run_s ##1 div_run_s ##1 div_finish_s)
    else $error("word divide timing wrong");

  div_zero_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == unsigned_divide && div_zero) |=>
      done_out && !write_out && flags_out[flag_v] && flags_out[flag_z])
    else $error("divide by zero wrong");

  addx_carry_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == add_with_carry && !word_in) |=>
      result_out[7:0] == 8'($past(dest_in[7:0]) + $past(source_operand_in[7:0]) + {7'h00, $past(carry_in)}))
    else $error("add with carry wrong");

  addx_word_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == add_with_carry && word_in) |=>
      result_out[15:0] == 16'($past(dest_in[15:0]) + $past(source_operand_in) + {15'h0000, $past(carry_in)}))
    else $error("word add with carry wrong");

  subtract_with_borrow_borrow_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == subtract_with_borrow && !word_in) |=>
      result_out[7:0] == 8'($past(dest_in[7:0]) - $past(source_operand_in[7:0]) - {7'h00, $past(carry_in)}))
    else $error("subtract with borrow wrong");

  bcd_add_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == decimal_add && dest_in[7:0] == 8'h09 && source_operand_in[7:0] == 8'h01
     && !carry_in) |=> result_out[7:0] == 8'h10 && !flags_out[flag_c])
    else $error("decimal add wrong");

  bcd_sub_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (start_in && !div_busy && op_in == decimal_subtract && dest_in[7:0] == 8'h00
     && source_operand_in[7:0] == 8'h01 && !carry_in) |=> result_out[7:0] == 8'h99 && flags_out[flag_c])
    else $error("decimal subtract wrong");

  flag_zero_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (done_out && write_out && $past(op_in) == sign_extend_byte) |-> flags_out[flag_z] == (result_out[15:0] == 16'h0000))
    else $error("zero flag wrong");
endmodule : integer_arithmetic_unit
`default_nettype wire

// File: bench/reg_file_model.sv
/*
  Register file stand-in: holds the destination operand, takes the write-back.
  Assumes the bench preloads it one cycle before each start.
*/
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic load_in,
  input wire logic [31:0] load_value_in,
  input wire logic write_in,
  input wire logic [31:0] result_in,
  output logic [31:0] value_out
);
  logic [31:0] held;
  // only load and the write strobe update it, so a stray or missing write shows as a wrong value
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      held <= 32'h0000_0000;
    end else if (load_in) begin
      held <= load_value_in;
    end else if (write_in) begin
      held <= result_in;
    end
  end
  assign value_out = held;
endmodule : reg_file_model
`default_nettype wire

// File: bench/tb.sv
/*
  Self-checking bench for the integer arithmetic unit, one task per scenario.
  Assumes the register file model feeds the destination operand.
*/
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb;
  import alu_pkg::*;
  logic ref_clk, resetn, start, word, carry, load, done, wr, wr_seen;
  alu_op_t op;
  logic [15:0] src;
  logic [31:0] dest, load_value, result, res;
  logic [3:0] flags, flg;
  int fails, num_checks, lat, cycle_count;

  integer_arithmetic_unit u_dut (.ref_clk_in(ref_clk), .resetn_in(resetn), .start_in(start),
    .op_in(op), .word_in(word), .dest_in(dest), .source_operand_in(src), .carry_in(carry),
    .done_out(done), .write_out(wr), .result_out(result), .flags_out(flags));
  reg_file_model u_regs (.clk_in(ref_clk), .resetn_in(resetn), .load_in(load),
    .load_value_in(load_value), .write_in(wr), .result_in(result), .value_out(dest));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // whole run is about 140 cycles
  always @(posedge ref_clk) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      fails++;
      tally_and_finish();
    end
  end

  // poke re-raises start mid-operation, which a busy divider must ignore
  task automatic do_op(input alu_op_t o, input logic w, input logic [31:0] d,
                       input logic [15:0] s, input logic c, input logic poke);
    @(posedge ref_clk); #1;
    load = 1'b1; load_value = d;
    @(posedge ref_clk); #1;
    load = 1'b0; start = 1'b1; op = o; word = w; src = s; carry = c;
    @(posedge ref_clk); #1;
    start = 1'b0; lat = 0;
    while (done !== 1'b1 && lat < 40) begin
      @(posedge ref_clk); #1;
      lat++;
      start = poke && lat == 3;
    end
    if (done !== 1'b1) begin fails++; $display("[FAIL] done expected 1 seen %b", done); end
    res = result; flg = flags; wr_seen = wr;
    @(posedge ref_clk); #1;
  endtask : do_op

  task automatic t_carry;
    do_op(add_with_carry, 1'b0, 32'h0000_12FF, 16'h0000, 1'b1, 1'b0);
    `CK("adc b", 16'h1200, res[15:0])
    `CK("adc c", 1'b1, flg[flag_c])
    `CK("adc wb", 16'h1200, dest[15:0])
    do_op(add_with_carry, 1'b1, 32'h0000_7FFF, 16'h0000, 1'b1, 1'b0);
    `CK("adc w", 16'h8000, res[15:0])
    `CK("adc nv", 2'b11, {flg[flag_n], flg[flag_v]})
    do_op(subtract_with_borrow, 1'b0, 32'h0000_3400, 16'h0001, 1'b1, 1'b0);
    `CK("sbb b", 16'h34FE, res[15:0])
    `CK("sbb nc", 2'b11, {flg[flag_n], flg[flag_c]})
    do_op(subtract_with_borrow, 1'b1, 32'h0000_5000, 16'h1000, 1'b0, 1'b0);
    `CK("sbb w", 16'h4000, res[15:0])
  endtask : t_carry

  task automatic t_decimal;
    do_op(decimal_add, 1'b0, 32'h0000_AB19, 16'h0028, 1'b1, 1'b0);
    `CK("decimal_add", 17'h0AB48, {flg[flag_c], res[15:0]})
    do_op(decimal_add, 1'b0, 32'h0000_AB99, 16'h0001, 1'b0, 1'b0);
    `CK("decimal_add cy", 17'h1AB00, {flg[flag_c], res[15:0]})
    do_op(decimal_subtract, 1'b0, 32'h0000_AB50, 16'h0025, 1'b1, 1'b0);
    `CK("decimal_subtract", 17'h0AB24, {flg[flag_c], res[15:0]})
    do_op(decimal_subtract, 1'b0, 32'h0000_AB00, 16'h0001, 1'b0, 1'b0);
    `CK("decimal_subtract bw", 17'h1AB99, {flg[flag_c], res[15:0]})
  endtask : t_decimal

  task automatic t_multiply;
    do_op(unsigned_multiply, 1'b0, 32'h0000_12FF, 16'h00FF, 1'b0, 1'b0);
    `CK("mul b", 16'hFE01, res[15:0])
    do_op(unsigned_multiply, 1'b1, 32'h0000_FFFF, 16'hFFFF, 1'b0, 1'b0);
    `CK("mul w", 32'hFFFE_0001, res)
    `CK("mul vc", 2'b00, {flg[flag_v], flg[flag_c]})
    `CK("mul wb", 32'hFFFE_0001, dest)
  endtask : t_multiply

  task automatic t_divide;
    do_op(unsigned_divide, 1'b0, 32'h0000_1234, 16'h0056, 1'b0, 1'b1);
    `CK("div b", 16'h1036, res[15:0])
    `CK("div b lat", 9, lat)
    `CK("div b f", 4'h0, flg)
    do_op(unsigned_divide, 1'b1, 32'h0001_0000, 16'h0003, 1'b0, 1'b0);
    `CK("div w", 32'h0001_5555, res)
    `CK("div w lat", 17, lat)
    do_op(unsigned_divide, 1'b1, 32'h0000_1234, 16'h0000, 1'b0, 1'b0);
    `CK("div0", 6'b0_1_0110, {wr_seen, lat == 0, flg})
    `CK("div0 kept", 16'h1234, dest[15:0])
  endtask : t_divide

  task automatic t_compare;
    do_op(compare_op, 1'b1, 32'h0000_1234, 16'h1234, 1'b0, 1'b0);
    `CK("cmp eq", 3'b010, {wr_seen, flg[flag_z], flg[flag_c]})
    `CK("cmp kept", 16'h1234, dest[15:0])
    do_op(compare_op, 1'b0, 32'h0000_7701, 16'h0002, 1'b0, 1'b0);
    `CK("cmp lt", 3'b011, {wr_seen, flg[flag_n], flg[flag_c]})
    do_op(zero_compare, 1'b0, 32'h0000_0080, 16'h0000, 1'b0, 1'b0);
    `CK("tst n", 3'b010, {wr_seen, flg[flag_n], flg[flag_z]})
    do_op(zero_compare, 1'b1, 32'h0000_0000, 16'h0000, 1'b0, 1'b0);
    `CK("tst z", 2'b01, {wr_seen, flg[flag_z]})
  endtask : t_compare

  task automatic t_unary;
    do_op(sign_extend_byte, 1'b0, 32'h0000_3480, 16'h0000, 1'b0, 1'b0);
    `CK("sign_extend_byte neg", 16'hFF80, dest[15:0])
    do_op(sign_extend_byte, 1'b0, 32'h0000_FF7F, 16'h0000, 1'b0, 1'b0);
    `CK("sign_extend_byte pos", 16'h007F, dest[15:0])
    do_op(zero_extend_byte, 1'b0, 32'h0000_AB80, 16'h0000, 1'b0, 1'b0);
    `CK("zero_extend_byte", 16'h0080, dest[15:0])
    do_op(negate_op, 1'b0, 32'h0000_5501, 16'h0000, 1'b0, 1'b0);
    `CK("neg b", 16'h55FF, dest[15:0])
    do_op(negate_op, 1'b1, 32'h0000_0001, 16'h0000, 1'b0, 1'b0);
    `CK("neg w", 16'hFFFF, dest[15:0])
    do_op(zero_store, 1'b1, 32'h0000_BEEF, 16'h0000, 1'b0, 1'b0);
    `CK("clr w", 17'h10000, {flg[flag_z], dest[15:0]})
    do_op(zero_store, 1'b0, 32'h0000_12AB, 16'h0000, 1'b0, 1'b0);
    `CK("clr b", 16'h1200, dest[15:0])
    do_op(test_then_set_msb, 1'b0, 32'h0000_3400, 16'h0000, 1'b0, 1'b0);
    `CK("tas z", 17'h13480, {flg[flag_z], dest[15:0]})
    do_op(test_then_set_msb, 1'b0, 32'h0000_0080, 16'h0000, 1'b0, 1'b0);
    `CK("tas n", 18'h20080, {flg[flag_n], flg[flag_z], dest[15:0]})
  endtask : t_unary

  initial begin
    resetn = 1'b0; start = 1'b0; op = add_with_carry; word = 1'b0; src = 16'h0000;
    carry = 1'b0; load = 1'b0; load_value = 32'h0000_0000;
    fails = 0; num_checks = 0; cycle_count = 0;
    repeat (8) @(posedge ref_clk);
    #1 resetn = 1'b1;
    t_carry();
    t_decimal();
    t_multiply();
    t_divide();
    t_compare();
    t_unary();
    tally_and_finish();
  end
endmodule : tb
`undef CK
`default_nettype wire
